// >>> src/ebr_report.sv
`timescale 1ns/1ns
module ebr_report (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pageDone,
    input wire logic eccEnable,
    input wire logic [15:0] rawCounts,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata
);
    // =======================================
    // threshold setting
    logic [3:0] thresh_q;
    logic [3:0] thresh_d;

    always_comb begin
        thresh_d = thresh_q;
        // low nibble is reserved and dropped
        if (regWrite && regAddr == ebr_pkg::ADDR_THRESH) begin
            thresh_d = regWdata[ebr_pkg::THRESH_LSB +: 4];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            thresh_q <= ebr_pkg::THRESH_RESET;
        end else begin
            thresh_q <= thresh_d;
        end
    end

    // =======================================
    // page results
    ebr_result_if res ();

    ebr_page_calc u_calc (
        .rawCounts(rawCounts),
        .threshold(thresh_q),
        .res(res)
    );

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [7:0] max_q;
    logic [7:0] max_d;
    logic capture;

    // without ecc the counts mean nothing, so the last report stays
    assign capture = pageDone && eccEnable;

    always_comb begin
        cnt_d = cnt_q;
        flags_d = flags_q;
        max_d = max_q;
        if (capture) begin
            cnt_d = res.counts;
            flags_d = res.flags;
            max_d = {res.maxCount, 1'b0, res.maxSector};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= ebr_pkg::CNT_RESET;
            flags_q <= ebr_pkg::FLAGS_RESET;
            max_q <= ebr_pkg::MAX_RESET;
        end else begin
            cnt_q <= cnt_d;
            flags_q <= flags_d;
            max_q <= max_d;
        end
    end

    // =======================================
    // read data, registered so the host never samples a mux in motion
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        // reserved bits read zero, the host must not rely on it
        case (regAddr)
            ebr_pkg::ADDR_THRESH: rdata_d = {thresh_q, 4'h0};
            ebr_pkg::ADDR_FLAGS: rdata_d = {4'h0, flags_q};
            ebr_pkg::ADDR_MAX: rdata_d = max_q;
            ebr_pkg::ADDR_CNT_LO: rdata_d = cnt_q[7:0];
            ebr_pkg::ADDR_CNT_HI: rdata_d = cnt_q[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= ebr_pkg::RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    // =======================================
    // checks
    chk_flag_set: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture))
        |-> flags_q[0] == (cnt_q[3:0] >= $past(thresh_q)))
        else $error("flag 0 mismatch");
    chk_flag_low: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[7:4] < $past(thresh_q)) |-> !flags_q[1])
        else $error("flag 1 set below threshold");
    chk_cnt_range: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q[3:0] <= ebr_pkg::CNT_MAX_CORR || cnt_q[3:0] == ebr_pkg::CNT_UNCORR)
        else $error("count out of range");
    chk_cnt_sat: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[15:12] > ebr_pkg::CNT_MAX_CORR) |=> cnt_q[15:12] == 4'hf)
        else $error("no saturation");
    chk_max_uncorr: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q[3:0] == 4'hf) |-> max_q[7:4] == 4'hf)
        else $error("max not all ones");
    chk_max_ge: assert property (@(posedge clk) disable iff (!nrst)
        max_q[7:4] >= cnt_q[11:8] && max_q[7:4] >= cnt_q[7:4])
        else $error("max below a sector");
    chk_max_zero: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q == 16'h0000) |-> max_q == 8'h00)
        else $error("clean page max nonzero");
    chk_tie_low: assert property (@(posedge clk) disable iff (!nrst)
        (max_q[7:4] == cnt_q[3:0]) |-> max_q[2:0] == 3'h0)
        else $error("tie not lowest");
    chk_hold: assert property (@(posedge clk) disable iff (!nrst)
        !capture |=> $stable(cnt_q) && $stable(max_q) && $stable(flags_q))
        else $error("report changed without page read");

    // =======================================
    // per-sector checks, one property each so a failure names its sector
    chk_set_sec1: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[7:4] >= $past(thresh_q))
        |-> flags_q[1])
        else $error("flag 1 clear at threshold");

    chk_set_sec2: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[11:8] >= $past(thresh_q))
        |-> flags_q[2])
        else $error("flag 2 clear at threshold");

    chk_set_sec3: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[15:12] >= $past(thresh_q))
        |-> flags_q[3])
        else $error("flag 3 clear at threshold");

    chk_low_sec0: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[3:0] < $past(thresh_q))
        |-> !flags_q[0])
        else $error("flag 0 set below threshold");

    chk_low_sec2: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[11:8] < $past(thresh_q))
        |-> !flags_q[2])
        else $error("flag 2 set below threshold");

    chk_low_sec3: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(capture) && cnt_q[15:12] < $past(thresh_q))
        |-> !flags_q[3])
        else $error("flag 3 set below threshold");

    chk_range_sec1: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q[7:4] <= ebr_pkg::CNT_MAX_CORR
        || cnt_q[7:4] == ebr_pkg::CNT_UNCORR)
        else $error("count 1 out of range");

    chk_range_sec2: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q[11:8] <= ebr_pkg::CNT_MAX_CORR
        || cnt_q[11:8] == ebr_pkg::CNT_UNCORR)
        else $error("count 2 out of range");

    chk_range_sec3: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q[15:12] <= ebr_pkg::CNT_MAX_CORR
        || cnt_q[15:12] == ebr_pkg::CNT_UNCORR)
        else $error("count 3 out of range");

    chk_sat_sec0: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[3:0] > ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[3:0] == ebr_pkg::CNT_UNCORR)
        else $error("count 0 not saturated");

    chk_sat_sec1: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[7:4] > ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[7:4] == ebr_pkg::CNT_UNCORR)
        else $error("count 1 not saturated");

    chk_sat_sec2: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[11:8] > ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[11:8] == ebr_pkg::CNT_UNCORR)
        else $error("count 2 not saturated");

    chk_pass_sec0: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[3:0] <= ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[3:0] == $past(rawCounts[3:0]))
        else $error("count 0 not in place");

    chk_pass_sec1: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[7:4] <= ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[7:4] == $past(rawCounts[7:4]))
        else $error("count 1 not in place");

    chk_pass_sec2: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[11:8] <= ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[11:8] == $past(rawCounts[11:8]))
        else $error("count 2 not in place");

    chk_pass_sec3: assert property (@(posedge clk) disable iff (!nrst)
        (capture && rawCounts[15:12] <= ebr_pkg::CNT_MAX_CORR)
        |=> cnt_q[15:12] == $past(rawCounts[15:12]))
        else $error("count 3 not in place");

    chk_tie_sec1: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q[7:4] == max_q[7:4] && cnt_q[3:0] < max_q[7:4])
        |-> max_q[2:0] == 3'h1)
        else $error("tie not lowest at sector 1");

    chk_tie_sec2: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q[11:8] == max_q[7:4] && cnt_q[3:0] < max_q[7:4] && cnt_q[7:4] < max_q[7:4])
        |-> max_q[2:0] == 3'h2)
        else $error("tie not lowest at sector 2");

    chk_tie_sec3: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q[15:12] == max_q[7:4] && cnt_q[3:0] < max_q[7:4]
        && cnt_q[7:4] < max_q[7:4] && cnt_q[11:8] < max_q[7:4])
        |-> max_q[2:0] == 3'h3)
        else $error("tie not lowest at sector 3");

    // =======================================
    // page maximum
    // nibble of a packed count word, picked by sector number
    function automatic logic [3:0] nibble(input logic [15:0] v, input logic [2:0] idx);
        nibble = v[idx[1:0]*4 +: 4];
    endfunction : nibble

    chk_max_hit: assert property (@(posedge clk) disable iff (!nrst)
        max_q[7:4] == nibble(cnt_q, max_q[2:0]))
        else $error("max not held by its sector");

    chk_max_edge: assert property (@(posedge clk) disable iff (!nrst)
        max_q[7:4] >= cnt_q[3:0]
        && max_q[7:4] >= cnt_q[15:12])
        else $error("max below an outer sector");

    chk_sec_range: assert property (@(posedge clk) disable iff (!nrst)
        max_q[2:0] <= 3'h3)
        else $error("max sector out of range");

    chk_uncorr_any: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q[7:4] == ebr_pkg::CNT_UNCORR || cnt_q[11:8] == ebr_pkg::CNT_UNCORR
        || cnt_q[15:12] == ebr_pkg::CNT_UNCORR)
        |-> max_q[7:4] == ebr_pkg::CNT_UNCORR)
        else $error("uncorrected sector, max not all ones");

    chk_max_nonzero: assert property (@(posedge clk) disable iff (!nrst)
        (cnt_q != 16'h0000)
        |-> max_q[7:4] != 4'h0)
        else $error("dirty page max zero");

    // =======================================
    // capture, hold and threshold
    chk_no_ecc: assert property (@(posedge clk) disable iff (!nrst)
        (pageDone && !eccEnable)
        |=> $stable(cnt_q) && $stable(flags_q) && $stable(max_q))
        else $error("report moved without ecc");

    chk_thresh_wr: assert property (@(posedge clk) disable iff (!nrst)
        (regWrite && regAddr == ebr_pkg::ADDR_THRESH)
        |=> thresh_q == $past(regWdata[ebr_pkg::THRESH_LSB +: 4]))
        else $error("threshold write lost");

    chk_thresh_hold: assert property (@(posedge clk) disable iff (!nrst)
        !(regWrite && regAddr == ebr_pkg::ADDR_THRESH)
        |=> $stable(thresh_q))
        else $error("threshold moved without write");

    // =======================================
    // read data, checked one edge after the address
    chk_rd_thresh: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(regAddr) == ebr_pkg::ADDR_THRESH)
        |-> regRdata[7:4] == $past(thresh_q))
        else $error("threshold readback wrong");

    chk_rd_flags: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(regAddr) == ebr_pkg::ADDR_FLAGS)
        |-> regRdata[3:0] == $past(flags_q))
        else $error("flag readback wrong");

    chk_rd_max: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(regAddr) == ebr_pkg::ADDR_MAX)
        |-> regRdata == $past(max_q))
        else $error("max readback wrong");

    chk_rd_lo: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(regAddr) == ebr_pkg::ADDR_CNT_LO)
        |-> regRdata == $past(cnt_q[7:0]))
        else $error("low count readback wrong");

    chk_rd_hi: assert property (@(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(regAddr) == ebr_pkg::ADDR_CNT_HI)
        |-> regRdata == $past(cnt_q[15:8]))
        else $error("high count readback wrong");
endmodule : ebr_report

// >>> src/ebr_pkg.sv
package ebr_pkg;
    localparam logic [7:0] ADDR_THRESH = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h20;
    localparam logic [7:0] ADDR_MAX = 8'h30;
    localparam logic [7:0] ADDR_CNT_LO = 8'h40;
    localparam logic [7:0] ADDR_CNT_HI = 8'h50;
    localparam int THRESH_LSB = 4;
    localparam int MAX_CNT_LSB = 4;
    localparam logic [3:0] THRESH_RESET = 4'h4;
    localparam logic [3:0] CNT_MAX_CORR = 4'h8;
    localparam logic [3:0] CNT_UNCORR = 4'hf;
    localparam int NUM_SECTORS = 4;
    localparam int CNT_W = 4;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] MAX_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage : ebr_pkg

// >>> src/ebr_result_if.sv
`timescale 1ns/1ns
interface ebr_result_if;
    logic [15:0] counts;
    logic [3:0] flags;
    logic [3:0] maxCount;
    logic [2:0] maxSector;
    modport calc (output counts, output flags, output maxCount, output maxSector);
    modport user (input counts, input flags, input maxCount, input maxSector);
endinterface : ebr_result_if

// >>> src/ebr_page_calc.sv
`timescale 1ns/1ns
module ebr_page_calc (
    input wire logic [15:0] rawCounts,
    input wire logic [3:0] threshold,
    ebr_result_if.calc res
);
    // =======================================
    // saturating encode of one raw count
    function automatic logic [3:0] encCount(input logic [3:0] raw);
        // anything past eight was not corrected
        if (raw > ebr_pkg::CNT_MAX_CORR) begin
            encCount = ebr_pkg::CNT_UNCORR;
        end else begin
            encCount = raw;
        end
    endfunction : encCount

    always_comb begin
        logic [3:0] c;
        logic [3:0] best;
        logic [2:0] bestIdx;
        c = 4'h0;
        best = 4'h0;
        bestIdx = 3'h0;
        res.counts = 16'h0000;
        res.flags = 4'h0;
        for (int s = 0; s < ebr_pkg::NUM_SECTORS; s++) begin
            c = encCount(rawCounts[s*4 +: 4]);
            res.counts[s*4 +: 4] = c;
            res.flags[s] = (c >= threshold);
            // strict compare keeps the lower sector on a tie
            if (c > best) begin
                best = c;
                bestIdx = 3'(s);
            end
        end
        res.maxCount = best;
        res.maxSector = bestIdx;
    end
endmodule : ebr_page_calc

// >>> verif/ebr_host_model.sv
`timescale 1ns/1ns
// ====
// host side of the status access
module ebr_host_model (
    input wire logic clk,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d & 8'hf0;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regWdata = ~regWdata;
    endtask : wr
    // reserved bits masked, their value is not defined
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] m;
        m = a == 8'h10 ? 8'hf0 : a == 8'h20 ? 8'h0f : a == 8'h30 ? 8'hf7 : 8'hff;
        @(negedge clk);
        regAddr = a;
        // read data is registered, settled one edge later
        @(negedge clk);
        d = regRdata & m;
    endtask : rd
endmodule : ebr_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ns
// ====
// bench
module tb_top;
    logic clk, nrst, pageDone, eccEnable, regWrite;
    logic [15:0] rawCounts;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [15:0] corner [6] = '{16'h0000, 16'h8888, 16'hffff, 16'h3902, 16'h5955, 16'h6631};
    logic [15:0] rv;
    logic [31:0] e;
    logic [3:0] thr;
    int fails, samples_checked;
    ebr_report dut (.clk(clk), .nrst(nrst), .pageDone(pageDone), .eccEnable(eccEnable),
        .rawCounts(rawCounts), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata));
    ebr_host_model host (.clk(clk), .regRdata(regRdata), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // strict greater keeps the lowest sector on ties
    function automatic logic [31:0] exp_of(input logic [15:0] raw, input logic [3:0] t);
        logic [3:0] c, mx, fl;
        logic [2:0] ms;
        logic [15:0] sc;
        mx = 4'h0;
        ms = 3'h0;
        for (int s = 0; s < 4; s++) begin
            c = raw[4*s+:4] > 4'h8 ? 4'hf : raw[4*s+:4];
            sc[4*s+:4] = c;
            fl[s] = c >= t;
            if (c > mx) begin
                mx = c;
                ms = s[2:0];
            end
        end
        return {4'h0, fl, mx, 1'b0, ms, sc};
    endfunction : exp_of
    task automatic chk_all(input logic [31:0] x);
        logic [7:0] d;
        host.rd(8'h10, d);
        chk(d, {thr, 4'h0});
        host.rd(8'h20, d);
        chk(d, x[31:24]);
        host.rd(8'h30, d);
        chk(d, x[23:16]);
        host.rd(8'h40, d);
        chk(d, x[7:0]);
        host.rd(8'h50, d);
        chk(d, x[15:8]);
    endtask : chk_all
    task automatic page(input logic [15:0] raw, input logic en);
        @(negedge clk);
        rawCounts = raw;
        eccEnable = en;
        pageDone = 1'b1;
        @(negedge clk);
        pageDone = 1'b0;
    endtask : page
    initial begin
        #100000 fails++;
        conclude();
    end
    initial begin
        {nrst, pageDone, eccEnable, rawCounts} = '0;
        thr = 4'h4;
        void'($urandom(81341));
        repeat (2) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        chk_all(exp_of(16'h0000, thr));
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            thr = i < 16 ? i[3:0] : 4'($urandom_range(1, 8));
            host.wr(8'h10, {thr, 4'h0});
            rv = i < 6 ? corner[i] : 16'($urandom);
            e = exp_of(rv, thr);
            page(rv, 1'b1);
            chk_all(e);
        end
        $display("test pages done");
        e = exp_of(rawCounts, thr);
        // no ecc pass, stale results must stand
        page(~rawCounts, 1'b0);
        thr = thr + 4'h1;
        host.wr(8'h10, {thr, 4'h0});
        host.wr(8'h30, 8'hff);
        host.wr(8'h40, 8'hff);
        chk_all(e);
        $display("test hold done");
        @(negedge clk) nrst = 1'b0;
        @(negedge clk) nrst = 1'b1;
        thr = 4'h4;
        chk_all(exp_of(16'h0000, thr));
        $display("test rereset done");
        conclude();
    end
endmodule : tb_top
